// ===== verilog/meas_sched_pkg.sv
/*
 Shared constants, types and carriers for the measurement cycle scheduler.
 Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package meas_sched_pkg;

   // Time base and typical phase durations
   localparam int CLK_MHZ     = 100;
   localparam int WORST_PCT   = 110;   // Oscillator may run 10 % slow
   localparam int T_WAKE_US   = 100;
   localparam int T_CCALC_US  = 300;
   localparam int T_TCALC_US  = 250;
   localparam int T_CONV8_US  = 300;
   localparam int T_CONV10_US = 1150;
   localparam int T_CONV12_US = 4500;
   localparam int T_CONV14_US = 18000;
   localparam int T_PD1_MS    = 5;
   localparam int T_PD2_MS    = 25;
   localparam int T_PD3_MS    = 125;

   localparam int WAKE_CYC_DEF   = T_WAKE_US * CLK_MHZ;
   localparam int CCALC_CYC_DEF  = T_CCALC_US * CLK_MHZ;
   localparam int TCALC_CYC_DEF  = T_TCALC_US * CLK_MHZ;
   localparam int CONV8_CYC_DEF  = T_CONV8_US * CLK_MHZ;
   localparam int CONV10_CYC_DEF = T_CONV10_US * CLK_MHZ;
   localparam int CONV12_CYC_DEF = T_CONV12_US * CLK_MHZ;
   localparam int CONV14_CYC_DEF = T_CONV14_US * CLK_MHZ;
   localparam int PD1_CYC_DEF    = T_PD1_MS * 1000 * CLK_MHZ;
   localparam int PD2_CYC_DEF    = T_PD2_MS * 1000 * CLK_MHZ;
   localparam int PD3_CYC_DEF    = T_PD3_MS * 1000 * CLK_MHZ;

   // Register map (byte addresses) and fields
   localparam logic [7:0] OFS_FCFG = 8'h00;
   localparam logic [7:0] OFS_CCFG = 8'h04;
   localparam logic [7:0] OFS_TCFG = 8'h08;
   localparam logic [7:0] OFS_CMD  = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam int FCFG_PERIODIC_BIT = 0;
   localparam int FCFG_RATE_LSB     = 1;
   localparam int RES_LSB           = 0;
   localparam int CMD_REQ_BIT       = 0;
   localparam logic       PERIODIC_RST = 1'b0;
   localparam logic [1:0] RATE_RST     = 2'h0;
   localparam logic [1:0] RES_RST      = 2'h0;
   localparam logic [2:0] TEMP_EVERY   = 3'h6;

   typedef enum logic [2:0] {
      PH_IDLE   = 3'b000,
      PH_WAKE   = 3'b001,
      PH_TCONV  = 3'b010,
      PH_TCALC  = 3'b011,
      PH_CCONV  = 3'b100,
      PH_CCALC  = 3'b101,
      PH_UPDATE = 3'b110,
      PH_PDOWN  = 3'b111
   } phase_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic       wake;
      logic       conv;
      logic       conv_temp;
      logic       calc;
      logic       calc_temp;
      logic [1:0] res;
      logic       result_update;
      logic       temp_update;
      logic       pdown;
   } phase_out_s;

   typedef struct packed {
      phase_e      st;
      logic        periodic;
      logic [1:0]  rate;
      logic [1:0]  cres;
      logic [1:0]  tres;
      logic        req;
      logic        cyc_periodic;
      logic        with_temp;
      logic [1:0]  res_c;
      logic [1:0]  res_t;
      logic [2:0]  tcnt;
      logic [15:0] ncyc;
      logic [31:0] prdata;
   } sched_s;

   typedef struct packed {
      logic [31:0] cnt;
   } timer_s;

endpackage

// ===== verilog/phase_timer.sv
/*
 Down counter that times one scheduler phase.
 Assumes the caller loads it on the edge that enters the phase.
*/
module phase_timer (
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // Load and expiry
   input  wire logic        i_load,
   input  wire logic [31:0] i_count,
   output logic             o_done
);
   import meas_sched_pkg::*;

   timer_s t_reg;
   timer_s t_next;

   // Done in the last of the loaded number of cycles
   assign o_done = (t_reg.cnt == 32'h1);

   always_comb begin
      t_next = t_reg;
      if (i_load) begin
         t_next.cnt = i_count;
      end else if (t_reg.cnt != 32'h0) begin
         t_next.cnt = t_reg.cnt - 32'h1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end
endmodule

// ===== verilog/meas_cycle_scheduler.sv
/*
 Measurement cycle scheduler with its APB register file.
 Assumes a zero-wait APB master on i_mclk and that the front end follows the phase outputs.
*/
// How it works
// RULE1 - Wakeup, temperature pair, then capacitance pair
// RULE2 - Conversion length follows two-bit resolution code
// RULE3 - Capacitance and temperature resolution from separate words
// RULE4 - Correction calculation follows every conversion
// RULE5 - Periodic cycles mostly skip temperature
// RULE6 - One bit selects periodic or sleep operation
// RULE7 - Sleep: no measurement without host request
// RULE8 - Update code sets power-down period
// RULE9 - Results updated before power-down
// RULE10 - Power-down expiry starts next cycle
// RULE11 - Fastest code runs cycles back to back
// RULE12 - One temperature per six capacitance measurements
// RULE13 - Capacitance immediately follows temperature
// RULE14 - Spacing is wakeup, conversion, calculation, power-down
// RULE15 - Temperature calculation adds its own time
// RULE16 - Worst case is typical times 1.1
// RULE17 - Periodic results drive every output form
// RULE18 - Sleep request runs temperature and capacitance
// RULE19 - Temperature counter cleared at startup, restarts
module meas_cycle_scheduler #(
   parameter int WAKE_CYC   = meas_sched_pkg::WAKE_CYC_DEF,
   parameter int CCALC_CYC  = meas_sched_pkg::CCALC_CYC_DEF,
   parameter int TCALC_CYC  = meas_sched_pkg::TCALC_CYC_DEF,
   parameter int CONV8_CYC  = meas_sched_pkg::CONV8_CYC_DEF,
   // Longer codes and rates scale from the shortest, so one override shrinks a whole set
   parameter int CONV10_CYC = CONV8_CYC * meas_sched_pkg::T_CONV10_US /
                              meas_sched_pkg::T_CONV8_US,
   parameter int CONV12_CYC = CONV8_CYC * meas_sched_pkg::T_CONV12_US /
                              meas_sched_pkg::T_CONV8_US,
   parameter int CONV14_CYC = CONV8_CYC * meas_sched_pkg::T_CONV14_US /
                              meas_sched_pkg::T_CONV8_US,
   parameter int PD1_CYC    = meas_sched_pkg::PD1_CYC_DEF,
   parameter int PD2_CYC    = PD1_CYC * meas_sched_pkg::T_PD2_MS / meas_sched_pkg::T_PD1_MS,
   parameter int PD3_CYC    = PD1_CYC * meas_sched_pkg::T_PD3_MS / meas_sched_pkg::T_PD1_MS
) (
   // Clock and reset
   input  wire logic                        i_mclk,
   input  wire logic                        i_rst_n,
   // Register bus
   input  wire meas_sched_pkg::apb_req_s    i_apb,
   output meas_sched_pkg::apb_rsp_s         o_apb,
   // Front end and result sequencing
   output meas_sched_pkg::phase_out_s       o_phase
);
   import meas_sched_pkg::*;

   sched_s      s_reg;
   sched_s      s_next;
   logic        tmr_load;
   logic [31:0] tmr_count;
   logic        tmr_done;
   logic        apb_wr;
   logic        apb_setup;
   logic        mapped;

   function automatic logic [31:0] conv_cycles(input logic [1:0] res); // RULE2
      case (res)
         2'h0:    conv_cycles = 32'(CONV8_CYC);
         2'h1:    conv_cycles = 32'(CONV10_CYC);
         2'h2:    conv_cycles = 32'(CONV12_CYC);
         default: conv_cycles = 32'(CONV14_CYC);
      endcase
   endfunction

   function automatic logic [31:0] pd_cycles(input logic [1:0] rate);
      case (rate)
         2'h1:    pd_cycles = 32'(PD1_CYC);
         2'h2:    pd_cycles = 32'(PD2_CYC);
         2'h3:    pd_cycles = 32'(PD3_CYC);
         default: pd_cycles = 32'h0;
      endcase
   endfunction

   // Duration of a phase when it is entered; durations are typical, not worst case
   function automatic logic [31:0] dur(input phase_e ph, input sched_s s); // RULE16
      case (ph)
         PH_WAKE:  dur = 32'(WAKE_CYC);
         PH_TCONV: dur = conv_cycles(s.res_t);
         PH_TCALC: dur = 32'(TCALC_CYC);                                         // RULE15
         PH_CCONV: dur = conv_cycles(s.res_c);
         PH_CCALC: dur = 32'(CCALC_CYC);
         PH_PDOWN: dur = pd_cycles(s.rate);
         default:  dur = 32'h0;
      endcase
   endfunction

   phase_timer u_timer (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_load  (tmr_load),
      .i_count (tmr_count),
      .o_done  (tmr_done)
   );

   assign apb_setup = i_apb.psel && !i_apb.penable;
   assign apb_wr    = i_apb.psel && i_apb.penable && i_apb.pwrite;
   assign mapped    = (i_apb.paddr == OFS_FCFG) || (i_apb.paddr == OFS_CCFG) ||
                      (i_apb.paddr == OFS_TCFG) || (i_apb.paddr == OFS_CMD) ||
                      (i_apb.paddr == OFS_STAT);

   // Zero-wait slave: every access phase completes at once
   assign o_apb.pready  = 1'b1;
   assign o_apb.pslverr = i_apb.psel && i_apb.penable && !mapped;
   assign o_apb.prdata  = s_reg.prdata;

   always_comb begin
      s_next    = s_reg;
      tmr_load  = 1'b0;
      tmr_count = 32'h0;

      // Register writes
      if (apb_wr && i_apb.paddr == OFS_FCFG) begin
         s_next.periodic = i_apb.pwdata[FCFG_PERIODIC_BIT];                      // RULE6
         s_next.rate     = i_apb.pwdata[FCFG_RATE_LSB +: 2];
      end
      if (apb_wr && i_apb.paddr == OFS_CCFG) begin
         s_next.cres = i_apb.pwdata[RES_LSB +: 2];
      end
      if (apb_wr && i_apb.paddr == OFS_TCFG) begin
         s_next.tres = i_apb.pwdata[RES_LSB +: 2];
      end

      // Sequencer
      case (s_reg.st)
         PH_IDLE: begin
            if (s_reg.periodic || s_reg.req) begin                               // RULE7
               s_next.st           = PH_WAKE;                                    // RULE1
               s_next.cyc_periodic = s_reg.periodic;
               s_next.with_temp    = !s_reg.periodic || (s_reg.tcnt == 3'h0);    // RULE18
               s_next.res_c        = s_reg.cres;                                 // RULE3
               s_next.res_t        = s_reg.tres;
               s_next.req          = s_reg.periodic ? s_reg.req : 1'b0;
            end
         end
         PH_WAKE: begin
            if (tmr_done) begin
               s_next.st = s_reg.with_temp ? PH_TCONV : PH_CCONV;                // RULE5
            end
         end
         PH_TCONV: begin
            if (tmr_done) begin
               s_next.st = PH_TCALC;                                             // RULE4
            end
         end
         PH_TCALC: begin
            if (tmr_done) begin
               s_next.st = PH_CCONV;                                             // RULE13
            end
         end
         PH_CCONV: begin
            if (tmr_done) begin
               s_next.st = PH_CCALC;                                             // RULE4
            end
         end
         PH_CCALC: begin
            if (tmr_done) begin
               s_next.st = PH_UPDATE;                                            // RULE9
            end
         end
         PH_UPDATE: begin
            s_next.ncyc = s_reg.ncyc + 16'h1;
            if (s_reg.with_temp) begin
               s_next.tcnt = 3'h1;                                               // RULE19
            end else if (s_reg.tcnt == TEMP_EVERY - 3'h1) begin
               s_next.tcnt = 3'h0;                                               // RULE12
            end else begin
               s_next.tcnt = s_reg.tcnt + 3'h1;
            end
            if (!s_reg.periodic) begin
               s_next.st = PH_IDLE;
            end else if (s_reg.rate == 2'h0) begin
               s_next.st           = PH_WAKE;                                    // RULE11
               s_next.cyc_periodic = 1'b1;
               s_next.with_temp    = s_reg.with_temp ? 1'b0 :
                                     (s_reg.tcnt == TEMP_EVERY - 3'h1);
               s_next.res_c        = s_reg.cres;
               s_next.res_t        = s_reg.tres;
            end else begin
               s_next.st = PH_PDOWN;                                             // RULE8
            end
         end
         PH_PDOWN: begin
            if (!s_reg.periodic) begin
               s_next.st = PH_IDLE;
            end else if (tmr_done) begin
               s_next.st           = PH_WAKE;                                    // RULE10
               s_next.cyc_periodic = 1'b1;
               s_next.with_temp    = (s_reg.tcnt == 3'h0);
               s_next.res_c        = s_reg.cres;
               s_next.res_t        = s_reg.tres;
            end
         end
         default: begin
            s_next.st = PH_IDLE;
         end
      endcase

      // A request written in the cycle it is taken still stands
      if (apb_wr && i_apb.paddr == OFS_CMD && i_apb.pwdata[CMD_REQ_BIT]) begin
         s_next.req = 1'b1;                                                      // RULE7
      end

      // Load the phase timer on entry to a timed phase
      if (s_next.st != s_reg.st || (s_reg.st == PH_UPDATE && s_next.st == PH_WAKE)) begin
         tmr_load  = 1'b1;
         tmr_count = dur(s_next.st, s_next);                                     // RULE14
      end

      // Read data is captured in the setup cycle
      if (apb_setup && !i_apb.pwrite) begin
         case (i_apb.paddr)
            OFS_FCFG: s_next.prdata = {29'h0, s_reg.rate, s_reg.periodic};
            OFS_CCFG: s_next.prdata = {30'h0, s_reg.cres};
            OFS_TCFG: s_next.prdata = {30'h0, s_reg.tres};
            OFS_STAT: s_next.prdata = {s_reg.ncyc, 7'h0, s_reg.with_temp,
                                       s_reg.cyc_periodic, s_reg.req,
                                       s_reg.tcnt, s_reg.st};
            default:  s_next.prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg          <= '0;
         s_reg.st       <= PH_IDLE;
         s_reg.periodic <= PERIODIC_RST;
         s_reg.rate     <= RATE_RST;
         s_reg.cres     <= RES_RST;
         s_reg.tres     <= RES_RST;
         s_reg.tcnt     <= 3'h0;                                                 // RULE19
      end else begin
         s_reg <= s_next;
      end
   end

   // Phase outputs; the update strobe feeds result register, density and alarm outputs alike
   assign o_phase.wake          = (s_reg.st == PH_WAKE);
   assign o_phase.conv          = (s_reg.st == PH_TCONV) || (s_reg.st == PH_CCONV);
   assign o_phase.conv_temp     = (s_reg.st == PH_TCONV);
   assign o_phase.calc          = (s_reg.st == PH_TCALC) || (s_reg.st == PH_CCALC);
   assign o_phase.calc_temp     = (s_reg.st == PH_TCALC);
   assign o_phase.res           = (s_reg.st == PH_TCONV) ? s_reg.res_t : s_reg.res_c;
   assign o_phase.result_update = (s_reg.st == PH_UPDATE);                       // RULE17
   assign o_phase.temp_update   = (s_reg.st == PH_UPDATE) && s_reg.with_temp;
   assign o_phase.pdown         = (s_reg.st == PH_PDOWN) || (s_reg.st == PH_IDLE);

   // Helper: cycles spent in the current phase
   logic [31:0] dwell;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dwell <= 32'h0;
      end else if (tmr_load) begin
         dwell <= 32'h0;
      end else begin
         dwell <= dwell + 32'h1;
      end
   end
   logic leaving;
   assign leaving = tmr_load;

   // Helper: rate that loaded the running power-down; a later write must not move it
   logic [1:0] pd_rate;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pd_rate <= 2'h0;
      end else if (s_reg.st == PH_UPDATE) begin
         pd_rate <= s_next.rate;
      end
   end

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   wake_first_a: assert property (                                               // RULE1
      (s_reg.st == PH_WAKE && $past(s_reg.st) != PH_WAKE) |->
         $past(s_reg.st) inside {PH_IDLE, PH_UPDATE, PH_PDOWN})
      else $error("cycle did not begin with wakeup");
   conv_len_a: assert property (                                                 // RULE2
      (s_reg.st == PH_CCONV && leaving) |-> dwell == conv_cycles(s_reg.res_c) - 32'h1)
      else $error("capacitance conversion length wrong");
   temp_res_a: assert property (                                                 // RULE3
      (s_reg.st == PH_TCONV && leaving) |->
         dwell == conv_cycles(s_reg.res_t) - 32'h1 && o_phase.res == s_reg.res_t)
      else $error("temperature conversion length wrong");
   calc_after_a: assert property (                                               // RULE4
      (s_reg.st inside {PH_TCONV, PH_CCONV} && leaving) |=> o_phase.calc)
      else $error("no calculation after conversion");
   skip_temp_a: assert property (                                                // RULE5
      (s_reg.st == PH_WAKE && s_reg.cyc_periodic && s_reg.tcnt != 3'h0) |->
         !s_reg.with_temp)
      else $error("temperature run off schedule");
   sleep_hold_a: assert property (                                               // RULE7
      (s_reg.st == PH_IDLE && !s_reg.periodic && !s_reg.req) |=> s_reg.st == PH_IDLE)
      else $error("measurement without request");
   pd_len_a: assert property (                                                   // RULE8
      (s_reg.st == PH_PDOWN && leaving && s_reg.periodic) |->
         dwell == pd_cycles(pd_rate) - 32'h1)
      else $error("power-down length wrong");
   update_first_a: assert property (                                             // RULE9
      (s_reg.st == PH_PDOWN && $past(s_reg.st) != PH_PDOWN) |->
         $past(s_reg.st) == PH_UPDATE)
      else $error("power-down without update");
   back_to_back_a: assert property (                                             // RULE11
      (s_reg.st == PH_UPDATE && s_reg.periodic && s_reg.rate == 2'h0) |=>
         s_reg.st == PH_WAKE)
      else $error("pause in back-to-back mode");
   six_count_a: assert property (                                                // RULE12
      s_reg.tcnt < TEMP_EVERY)
      else $error("temperature counter out of range");
   temp_then_cap_a: assert property (                                            // RULE13
      (s_reg.st == PH_TCALC && leaving) |->
         dwell == 32'(TCALC_CYC) - 32'h1 ##1 s_reg.st == PH_CCONV)
      else $error("capacitance did not follow temperature");
   sleep_temp_a: assert property (                                               // RULE18
      (s_reg.st == PH_WAKE && !s_reg.cyc_periodic) |-> s_reg.with_temp)
      else $error("sleep cycle without temperature");

   periodic_temp_c: cover property (s_reg.cyc_periodic && o_phase.temp_update);
   periodic_cap_c:  cover property (s_reg.cyc_periodic && o_phase.result_update &&
                                    !s_reg.with_temp);
   sleep_cycle_c:   cover property (!s_reg.cyc_periodic && o_phase.result_update);
   pdown_wake_c:    cover property (s_reg.st == PH_PDOWN ##1 s_reg.st == PH_WAKE);
endmodule

// ===== bench/host_model.sv
/*
 Host model: APB master that configures the scheduler and requests cycles.
 Assumes the bench calls its transfer task from one process at a time.
*/
module host_model (
   // Clock
   input  wire logic                     i_mclk,
   // Register bus
   output meas_sched_pkg::apb_req_s      o_req,
   input  wire meas_sched_pkg::apb_rsp_s i_rsp
);
   import meas_sched_pkg::*;

   initial begin
      o_req = '0;
   end

   // Released lines carry inverted values so a stale request cannot pass
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge i_mclk);
      o_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge i_mclk);
      o_req.penable <= 1'b1;
      do begin
         @(posedge i_mclk);
      end while (i_rsp.pready !== 1'b1);
      rd = i_rsp.prdata;
      err = i_rsp.pslverr;
      o_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~d};
   endtask
endmodule

// ===== bench/measurement_cycle_scheduler_test.sv
/*
 Self-checking bench for the measurement cycle scheduler.
 Assumes shortened phase counts so that every code and rate fits a short run.
*/
module measurement_cycle_scheduler_test;
   timeunit 1ns;
   timeprecision 1ps;
   import meas_sched_pkg::*;

   // Conversion and power-down ratios 0.30:1.15:4.50:18.0 and 0:5:25:125
   localparam int CONV[4] = '{5, 19, 75, 300};
   localparam int PDC[4]  = '{0, 10, 50, 250};

   logic        i_mclk;
   logic        i_rst_n;
   apb_req_s    req;
   apb_rsp_s    rsp;
   phase_out_s  ph;
   int          failures;
   int          tests_run;
   int          cnt[7];
   logic [1:0]  rt;
   logic [1:0]  rc;
   logic [31:0] rd;
   logic        err;

   meas_cycle_scheduler #(.WAKE_CYC(3), .CCALC_CYC(4), .TCALC_CYC(3), .CONV8_CYC(5),
      .PD1_CYC(10)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_apb(req),
      .o_apb(rsp), .o_phase(ph));

   host_model host (.i_mclk(i_mclk), .o_req(req), .i_rsp(rsp));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   task automatic wrap_up;
      if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rd, err);
   endtask

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic e);
      host.xfer(1'b0, a, 32'h0, rd, err);
      chk(what, exp, rd);
      chk({what, "_err"}, {31'h0, e}, {31'h0, err});
   endtask

   // Counts each phase until the end-of-cycle pulse; cnt[0] is power-down before wake
   task automatic grab;
      int n;
      n = 0;
      cnt = '{default: 0};
      do begin
         @(posedge i_mclk);
         #1;
         n++;
         if (ph.pdown === 1'b1) cnt[0]++;
         if (ph.wake === 1'b1) cnt[1]++;
         if (ph.conv_temp === 1'b1) begin
            cnt[2]++;
            rt = ph.res;
         end
         if (ph.calc_temp === 1'b1) cnt[3]++;
         if (ph.conv === 1'b1 && ph.conv_temp === 1'b0) begin
            cnt[4]++;
            rc = ph.res;
         end
         if (ph.calc === 1'b1 && ph.calc_temp === 1'b0) cnt[5]++;
      end while (ph.result_update !== 1'b1 && n < 3000);
      cnt[6] = (ph.temp_update === 1'b1);
      chk("cycle_end", 1, {31'h0, ph.result_update});
   endtask

   task automatic t_reset;
      rdchk("fcfg", OFS_FCFG, 32'h0, 1'b0);
      rdchk("ccfg", OFS_CCFG, 32'h0, 1'b0);
      rdchk("tcfg", OFS_TCFG, 32'h0, 1'b0);
      rdchk("stat", OFS_STAT, 32'h0, 1'b0);
      rdchk("unmapped", 8'h14, 32'h0, 1'b1);
      chk("pdown_rst", 1, {31'h0, ph.pdown});
   endtask

   task automatic t_sleep_wait;
      repeat (40) begin
         @(posedge i_mclk);
         #1;
         chk("idle_wake", 0, {31'h0, ph.wake});
      end
   endtask

   task automatic t_sleep_codes;
      for (int r = 0; r < 4; r++) begin
         wr(OFS_TCFG, r);
         wr(OFS_CCFG, 3 - r);
         wr(OFS_CMD, 32'h1);
         grab();
         chk("wake_len", 3, cnt[1]);
         chk("tconv_len", CONV[r], cnt[2]);
         chk("cconv_len", CONV[3-r], cnt[4]);
         chk("tres", r, rt);
         chk("cres", 3 - r, rc);
         chk("tcalc_len", 3, cnt[3]);
         chk("ccalc_len", 4, cnt[5]);
         chk("sleep_temp", 1, cnt[6]);
         @(posedge i_mclk);
         #1;
         chk("sleep_pdown", 1, {31'h0, ph.pdown});
      end
   endtask

   // Fresh reset so the temperature counter starts cleared
   task automatic t_periodic;
      @(posedge i_mclk);
      i_rst_n <= 1'b0;
      repeat (10) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      wr(OFS_FCFG, 32'h1);
      for (int k = 0; k < 7; k++) begin
         grab();
         chk("per_temp", (k % 6 == 0), cnt[6]);
         chk("per_tconv", (k % 6 == 0) ? 5 : 0, cnt[2]);
         chk("per_cconv", 5, cnt[4]);
         if (k > 0) chk("fast_gap", 0, cnt[0]);
      end
      host.xfer(1'b0, OFS_STAT, 32'h0, rd, err);
      chk("tcnt_restart", 1, {29'h0, rd[5:3]});
   endtask

   task automatic t_rates;
      for (int r = 1; r < 4; r++) begin
         wr(OFS_FCFG, {29'h0, r[1:0], 1'b1});
         grab();
         grab();
         chk("pdown_len", PDC[r], cnt[0]);
         chk("spacing_wake", 3, cnt[1]);
         chk("upd_before_pd", 0, {31'h0, ph.pdown});
      end
   endtask

   task automatic t_stop;
      wr(OFS_FCFG, 32'h0);
      repeat (60) @(posedge i_mclk);
      t_sleep_wait();
   endtask

   initial begin
      failures = 0;
      tests_run = 0;
      i_rst_n = 1'b0;
      repeat (10) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      t_reset();
      t_sleep_wait();
      t_sleep_codes();
      t_periodic();
      t_rates();
      t_stop();
      wrap_up();
   end

   // Whole run needs under two thousand cycles
   initial begin
      repeat (20000) @(posedge i_mclk);
      failures++;
      wrap_up();
   end
endmodule
